/* design/dig_ddr_input_gearing.sv */
// Contract
// [R1] capture serial data on both edge-clock edges
// [R2] second stage realigns bits per alignment control
// [R3] third stage hands word over on clk
// [R4] three register sets: shift, update, transfer
// [R5] side cells offer x1 and x2 gearing
// [R6] top cells offer x1 gearing only
// [R7] seven-to-one mode pairs two neighbouring cells
// [R8] user places seven-to-one on matched pin pair
// [R9] side cells stage words for memory interfacing
// [R10] programmable delay ahead of the registers; the code delays the update-stage word instead, after both capture stages
// [R11] earliest received bit sits at index zero
`timescale 1ns/1ps
`default_nettype none
module dig_ddr_input_gearing
    import dig_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  srst,
    input  wire logic                  edge_clk,
    input  wire logic                  data_pin,
    input  wire logic                  pair_pin,
    input  wire dig_cfg_t              cfg,
    input  wire logic                  align_slip,
    output logic [DIG_WORD_W-1:0]      word_data,
    output logic [DIG_CNT_W-1:0]       word_len,
    output logic                       word_valid
);

    // e runs on edge_clk, s on clk; only toggles and the held word cross between them
    // the held word is read only after its toggle has passed two clk flops
    dig_eclk_st_t e, next_e;
    dig_sys_st_t  s, next_s;
    logic         rise_own, fall_own, rise_pair, fall_pair;
    logic         erst_m, erst;
    logic [3:0]   stage_in;
    dig_mode_t    eff_mode;
    logic [DIG_CNT_W-1:0] add, wlen;
    logic         slip_evt, emit;

    // first stage: pins sampled on both edges; the pair cell only feeds seven-to-one
    // these flops stay outside the state bundle since half of them run on the falling edge
    always_ff @(posedge edge_clk) begin
        rise_own  <= data_pin;  // [R1]
        rise_pair <= pair_pin;  // [R7]
    end

    always_ff @(negedge edge_clk) begin
        fall_own  <= data_pin;  // [R1]
        fall_pair <= pair_pin;  // [R7]
    end

    // reset carried into the edge domain through two flops
    // erst lags srst by two edge cycles, so srst must outlast three of them
    always_ff @(posedge edge_clk) begin
        erst_m <= srst;
        erst   <= erst_m;
    end

    // edge domain: update stage, delay, alignment and word build
    always_comb begin
        logic [DIG_BUF_W-1:0] b;
        logic [DIG_CNT_W-1:0] c;
        logic [DIG_BUF_W-1:0] ext;
        b = '0;
        c = '0;
        ext = '0;
        next_e = e;
        next_e.cfg_m  = cfg;
        next_e.cfg_s  = e.cfg_m;
        next_e.slip_m = s.slip_tog;
        next_e.slip_s = e.slip_m;
        next_e.slip_d = e.slip_s;
        // rise bit precedes the fall bit of the same cycle
        next_e.cap = {fall_pair, rise_pair, fall_own, rise_own};  // [R4] [R11]
        next_e.dly[0] = e.cap;  // [R10]
        for (int i = 1; i < DIG_TAPS; i++) begin
            next_e.dly[i] = e.dly[i-1];
        end
        // limitation: a taps change mid-stream repeats or skips bits until realigned
        stage_in = (e.cfg_s.taps == 2'h0) ? e.cap : e.dly[e.cfg_s.taps - 2'h1];  // [R10]
        // top cells have no x2 or seven-to-one path
        eff_mode = e.cfg_s.top_cell ? DIG_GEAR_X1 : e.cfg_s.mode;  // [R5] [R6]
        case (eff_mode)
            DIG_GEAR_X1:    wlen = DIG_LEN_X1;
            DIG_GEAR_X2:    wlen = DIG_LEN_X2;
            DIG_GEAR_SEVEN: wlen = DIG_LEN_SEVEN;
            default:        wlen = DIG_LEN_X1;
        endcase
        add = (eff_mode == DIG_GEAR_SEVEN) ? DIG_ADD_PAIR : DIG_ADD_CELL;  // [R7]
        ext[3:0] = (add == DIG_ADD_PAIR) ? stage_in : {2'h0, stage_in[1:0]};
        // new bits append above the held ones, so older bits stay low
        b = e.shift | (ext << e.cnt);  // [R11]
        c = e.cnt + add;
        // a slip drops the oldest bit, moving the word boundary by one
        // two slips closer than one edge cycle can cancel out and leave no slip
        slip_evt = e.slip_s ^ e.slip_d;
        if (slip_evt) begin
            b = b >> 1;  // [R2]
            c = c - 5'h01;
        end
        // bits past the word end stay in the buffer and start the next word
        emit = (c >= wlen);
        if (emit) begin
            next_e.word.data = b[DIG_WORD_W-1:0] & ~(7'h7f << wlen);  // [R2] [R11]
            next_e.word.len  = wlen;
            next_e.tog       = ~e.tog;  // [R9]
            b = b >> wlen;
            c = c - wlen;
        end
        next_e.shift = b;
        next_e.cnt   = c;
    end

    always_ff @(posedge edge_clk) begin
        if (erst) begin
            e <= DIG_ECLK_RST;
        end else begin
            e <= next_e;
        end
    end

    // system domain: word held by the edge side until the next toggle
    // the word is taken on the third clk edge after its toggle, before the edge side moves it
    always_comb begin
        next_s = s;
        next_s.tog_m = e.tog;
        next_s.tog_s = s.tog_m;
        next_s.tog_d = s.tog_s;
        next_s.valid = s.tog_s ^ s.tog_d;  // [R3]
        if (s.tog_s ^ s.tog_d) begin
            next_s.word = e.word;  // [R3] [R4]
        end
        next_s.slip_tog = s.slip_tog ^ align_slip;  // [R2]
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s <= DIG_SYS_RST;
        end else begin
            s <= next_s;
        end
    end

    // outputs come straight from the clk-side flops
    assign word_data  = s.word.data;
    assign word_len   = s.word.len;
    assign word_valid = s.valid;

    // checks on the edge domain; $past reaches back into reset, where all state is zero
    // several checks look at the registered word one edge after its toggle flipped,
    // so they test what was built rather than repeat the mode decode
    // the mode decode keeps top cells in x1
    top_x1_only_a: assert property (@(posedge edge_clk) disable iff (erst)  // [R6]
        e.cfg_s.top_cell |-> eff_mode == DIG_GEAR_X1 && add == DIG_ADD_CELL)
        else $error("top cell left x1 gearing");
    // whatever the mode field says, a top cell emits two-bit words
    top_word_len_a: assert property (@(posedge edge_clk) disable iff (erst)  // [R6]
        $changed(e.tog) && $past(e.cfg_s.top_cell) |-> e.word.len == DIG_LEN_X1)
        else $error("top cell word not x1 length");
    // side cells decode x2 to four-bit words
    side_modes_a: assert property (@(posedge edge_clk) disable iff (erst)  // [R5]
        !e.cfg_s.top_cell && e.cfg_s.mode == DIG_GEAR_X2 |-> wlen == DIG_LEN_X2)
        else $error("side cell x2 length wrong");
    // seven-to-one takes its bits from the cell pair
    pair_width_a: assert property (@(posedge edge_clk) disable iff (erst)  // [R7]
        eff_mode == DIG_GEAR_SEVEN |-> add == DIG_ADD_PAIR && wlen == DIG_LEN_SEVEN)
        else $error("seven-to-one not using pair");
    // with no emit and no slip the pair adds four bits a cycle
    pair_bits_a: assert property (@(posedge edge_clk) disable iff (erst)  // [R7]
        !$changed(e.tog) && !$past(slip_evt) && !$past(e.cfg_s.top_cell)
            && $past(e.cfg_s.mode) == DIG_GEAR_SEVEN
        |-> e.cnt == $past(e.cnt) + DIG_ADD_PAIR)
        else $error("pair did not add four bits");
    // a side cell in seven-to-one emits seven-bit words
    seven_word_len_a: assert property (@(posedge edge_clk) disable iff (erst)  // [R7]
        $changed(e.tog) && !$past(e.cfg_s.top_cell) && $past(e.cfg_s.mode) == DIG_GEAR_SEVEN
        |-> e.word.len == DIG_LEN_SEVEN)
        else $error("seven-to-one word length wrong");
    // the bit count after an emit accounts for every bit in and out
    word_count_a: assert property (@(posedge edge_clk) disable iff (erst)  // [R2]
        $changed(e.tog) |-> e.cnt == $past(e.cnt) + $past(add) - $past(wlen)
            - {4'h0, $past(slip_evt)})
        else $error("bit count wrong after emit");
    // a slip with no emit keeps one bit fewer than it took in
    slip_drop_a: assert property (@(posedge edge_clk) disable iff (erst)  // [R2]
        !$changed(e.tog) && $past(slip_evt)
        |-> e.cnt == $past(e.cnt) + $past(add) - 5'h01)
        else $error("slip did not drop a bit");
    // the staged word only moves together with its toggle
    word_hold_a: assert property (@(posedge edge_clk) disable iff (erst)  // [R9]
        !$changed(e.tog) |-> $stable(e.word))
        else $error("staged word moved without toggle");
    // the rising-edge bit reaches the update stage two edges after the pin
    rise_capture_a: assert property (@(posedge edge_clk) disable iff (erst)  // [R1]
        $past(erst) == 1'b0 |-> e.cap[0] == $past(data_pin, 2))
        else $error("rise bit not captured");
    // tap two gives exactly two cycles of delay
    delay_tap_a: assert property (@(posedge edge_clk) disable iff (erst)  // [R10]
        e.cfg_s.taps == 2'h2 && $stable(e.cfg_s) |-> stage_in == $past(e.cap, 2))
        else $error("delay tap two wrong");
    // the earliest bit lands at index zero
    bit_order_a: assert property (@(posedge edge_clk) disable iff (erst)  // [R11]
        emit && slip_evt == 1'b0 && e.cnt == 5'h00 && eff_mode == DIG_GEAR_X1
        |=> e.word.data[1:0] == $past(stage_in[1:0]))
        else $error("earliest bit not at index zero");

    // checks on the system domain
    // each toggle hands exactly the staged word over
    hand_over_a: assert property (@(posedge clk) disable iff (srst)  // [R3]
        s.tog_s != s.tog_d |=> s.valid && s.word == $past(e.word))
        else $error("word not handed over");
    // valid is a one-cycle pulse
    valid_pulse_a: assert property (@(posedge clk) disable iff (srst)  // [R4]
        s.valid |=> !s.valid)
        else $error("valid longer than one cycle");

    // scenarios worth seeing once in a run
    x1_word_c:    cover property (@(posedge clk) s.valid && s.word.len == DIG_LEN_X1);
    x2_word_c:    cover property (@(posedge clk) s.valid && s.word.len == DIG_LEN_X2);
    seven_word_c: cover property (@(posedge clk) s.valid && s.word.len == DIG_LEN_SEVEN);
    slip_c:       cover property (@(posedge edge_clk) slip_evt && emit);
    slip_drop_c:  cover property (@(posedge edge_clk) slip_evt && !emit);

endmodule : dig_ddr_input_gearing
`default_nettype wire

/* design/dig_pkg.sv */
package dig_pkg;

    // gearing modes, gray along x1 -> x2 -> seven-to-one
    typedef enum logic [1:0] {
        DIG_GEAR_X1    = 2'b00,
        DIG_GEAR_X2    = 2'b01,
        DIG_GEAR_SEVEN = 2'b11
    } dig_mode_t;

    localparam int DIG_WORD_W = 7;
    localparam int DIG_BUF_W  = 16;
    localparam int DIG_CNT_W  = 5;
    localparam int DIG_TAPS   = 3;

    // word lengths and bits gathered per edge-clock cycle
    localparam logic [DIG_CNT_W-1:0] DIG_LEN_X1    = 5'h02;
    localparam logic [DIG_CNT_W-1:0] DIG_LEN_X2    = 5'h04;
    localparam logic [DIG_CNT_W-1:0] DIG_LEN_SEVEN = 5'h07;
    localparam logic [DIG_CNT_W-1:0] DIG_ADD_CELL  = 5'h02;
    localparam logic [DIG_CNT_W-1:0] DIG_ADD_PAIR  = 5'h04;

    // quasi-static configuration, carried across as one bundle
    typedef struct packed {
        dig_mode_t   mode;
        logic        top_cell;
        logic [1:0]  taps;
    } dig_cfg_t;

    typedef struct packed {
        logic [DIG_WORD_W-1:0] data;
        logic [DIG_CNT_W-1:0]  len;
    } dig_word_t;

    // edge-clock domain state
    typedef struct packed {
        logic [3:0]                 cap;
        logic [DIG_TAPS-1:0][3:0]   dly;
        logic [DIG_BUF_W-1:0]       shift;
        logic [DIG_CNT_W-1:0]       cnt;
        dig_word_t                  word;
        logic                       tog;
        dig_cfg_t                   cfg_m;
        dig_cfg_t                   cfg_s;
        logic                       slip_m;
        logic                       slip_s;
        logic                       slip_d;
    } dig_eclk_st_t;

    // system clock domain state
    typedef struct packed {
        logic       tog_m;
        logic       tog_s;
        logic       tog_d;
        dig_word_t  word;
        logic       valid;
        logic       slip_tog;
    } dig_sys_st_t;

    localparam dig_eclk_st_t DIG_ECLK_RST = '0;
    localparam dig_sys_st_t  DIG_SYS_RST  = '0;

endpackage : dig_pkg

/* tb/dig_ddr_source.sv */
`timescale 1ns/1ps
`default_nettype none
// far-side transmitter: pat = {pair fall, pair rise, own fall, own rise}
module dig_ddr_source (
    input  wire logic       edge_clk,
    input  wire logic [3:0] pat,
    output var  logic       data_pin,
    output var  logic       pair_pin
);
    // launch a quarter period after each edge so capture never races;
    // one process drives both pins: rise bits after a fall, fall bits after a rise
    always @(edge_clk) begin
        #20;
        data_pin = edge_clk ? pat[1] : pat[0];
        pair_pin = edge_clk ? pat[3] : pat[2];
    end
endmodule : dig_ddr_source
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import dig_pkg::*;
    typedef struct packed {
        dig_cfg_t   cfg;
        logic [3:0] pat;
        logic [7:0] len;
        logic [7:0] data;
    } dig_tb_row_t;
    logic                  clk = 1'b0;
    logic                  edge_clk = 1'b0;
    logic                  srst, align_slip, data_pin, pair_pin, word_valid;
    logic [3:0]            pat;
    dig_cfg_t              cfg;
    logic [DIG_WORD_W-1:0] word_data;
    logic [DIG_CNT_W-1:0]  word_len;
    dig_tb_row_t           rows [6];
    int                    n_fail = 0;
    int                    n_checks = 0;
    always #12.5 clk = ~clk;
    // link clock free running, phase unrelated to clk
    initial begin
        #7;
        forever #40 edge_clk = ~edge_clk;
    end
    dig_ddr_source src_u (.edge_clk(edge_clk), .pat(pat), .data_pin(data_pin),
        .pair_pin(pair_pin));
    dig_ddr_input_gearing dut_u (.clk(clk), .srst(srst), .edge_clk(edge_clk),
        .data_pin(data_pin), .pair_pin(pair_pin), .cfg(cfg), .align_slip(align_slip),
        .word_data(word_data), .word_len(word_len), .word_valid(word_valid));
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // bounded wait for n word pulses; returns just after the last one settles
    task automatic wait_words(input int n);
        int seen;
        seen = 0;
        for (int i = 0; i < 400 && seen < n; i++) begin
            @(posedge clk);
            #1;
            if (word_valid === 1'b1) seen++;
        end
        if (seen < n) begin
            n_fail++;
            end_of_test();
        end
    endtask : wait_words
    // reset longer than three link cycles so the link side sees it too
    task automatic do_reset();
        @(posedge clk);
        #2 srst = 1'b1;
        repeat (12) @(posedge clk);
        #1;
        check({7'h00, word_valid}, 8'h00);
        check({3'h0, word_len}, 8'h00);
        #1 srst = 1'b0;
    endtask : do_reset
    initial begin
        srst = 1'b1;
        align_slip = 1'b0;
        pat = 4'h9;
        cfg = '0;
        rows[0] = '{'{DIG_GEAR_X1, 1'b0, 2'h0}, 4'h9, 8'h02, 8'h01};
        rows[1] = '{'{DIG_GEAR_X1, 1'b0, 2'h3}, 4'h5, 8'h02, 8'h01};
        rows[2] = '{'{DIG_GEAR_X2, 1'b0, 2'h1}, 4'hd, 8'h04, 8'h05};
        rows[3] = '{'{DIG_GEAR_X2, 1'b1, 2'h2}, 4'h1, 8'h02, 8'h01};
        rows[4] = '{'{DIG_GEAR_SEVEN, 1'b0, 2'h0}, 4'hf, 8'h07, 8'h7f};
        rows[5] = '{'{DIG_GEAR_SEVEN, 1'b1, 2'h1}, 4'hf, 8'h02, 8'h03};
        for (int r = 0; r < 6; r++) begin
            @(posedge clk);
            #2 cfg = rows[r].cfg;
            pat = rows[r].pat;
            do_reset();
            wait_words(12);
            check({3'h0, word_len}, rows[r].len);
            check({1'h0, word_data}, rows[r].data);
        end
        // one slip moves the boundary by a bit: rise bit lands on top
        cfg = rows[0].cfg;
        pat = rows[0].pat;
        do_reset();
        wait_words(8);
        @(posedge clk);
        #2 align_slip = 1'b1;
        @(posedge clk);
        #2 align_slip = 1'b0;
        wait_words(8);
        check({1'h0, word_data}, 8'h02);
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
